// file: rtl/dio_defs.svh
`ifndef DIO_DEFS_SVH
`define DIO_DEFS_SVH

// Number of bidirectional rear-panel pins.
`define DIO_PINS 7
// Core clock rate in MHz.
`define DIO_CLK_MHZ 250
// Least low time of a valid clear pulse on pin 1, in ns.
`define DIO_CLEAR_MIN_NS 30000
// Least low time, rounded up to whole core clock cycles.
`define DIO_CLEAR_MIN_CYC ((`DIO_CLEAR_MIN_NS * `DIO_CLK_MHZ + 999) / 1000)
// Low time of the pulse that pin 1 sends, in ns.
`define DIO_PULSE_OUT_NS 30000
// Sent pulse width, rounded up to whole core clock cycles.
`define DIO_PULSE_OUT_CYC ((`DIO_PULSE_OUT_NS * `DIO_CLK_MHZ + 999) / 1000)
// Width of the PWM period and low-time settings.
`define DIO_PWM_W 32
// Width of the pin 1 pulse timer.
`define DIO_TMR_W 32
// Level of a released pin, pulled high outside.
`define DIO_IDLE_LEVEL 1'b1

`endif

// file: rtl/dio_pkg.sv
package dio_pkg;

    // Function selected for a pin.
    typedef enum logic [1:0] {
        DIO_FN_DEFAULT,
        DIO_FN_INPUT,
        DIO_FN_OUTPUT
    } dio_func_t;

    // Value chosen for a pin in output mode.
    typedef enum logic [1:0] {
        DIO_OUT_TRUE,
        DIO_OUT_FALSE,
        DIO_OUT_PWM
    } dio_out_t;

    // States of the pin 1 protection-clear sequencer.
    typedef enum logic [1:0] {
        DIO_P1_IDLE,
        DIO_P1_LOW,
        DIO_P1_PULSE
    } dio_p1_state_t;

endpackage

// file: rtl/dio_pwm_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "dio_defs.svh"

// Settings into one PWM generator and its active phase back out.
interface dio_pwm_if;
    logic [`DIO_PWM_W-1:0] period;
    logic [`DIO_PWM_W-1:0] low_time;
    logic                  active;

    modport ctl (output period, output low_time, input active);
    modport gen (input period, input low_time, output active);
endinterface

`default_nettype wire

// file: rtl/dio_pwm.sv
`timescale 1ns/1ps
`default_nettype none
`include "dio_defs.svh"

module dio_pwm
    import dio_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Settings in, active phase out.
    dio_pwm_if.gen   bus
);

    logic [`DIO_PWM_W-1:0] cnt_q;
    logic [`DIO_PWM_W-1:0] cnt_d;
    logic                  act_q;
    logic                  act_d;

    // Period counter wraps at the period; active while below the low time.
    always_comb begin
        if ((bus.period == '0) || (cnt_q >= (`DIO_PWM_W)'(bus.period - 1'b1))) begin
            cnt_d = '0;
        end else begin
            cnt_d = (`DIO_PWM_W)'(cnt_q + 1'b1);
        end
        act_d = (bus.period != '0) && (cnt_d < bus.low_time); // R12
    end

    // Register the counter and the phase.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_q <= '0;
            act_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            act_q <= act_d;
        end
    end

    assign bus.active = act_q;

endmodule

`default_nettype wire

// file: rtl/dio_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dio_defs.svh"

// Overview of operation
// R1 - Input mode, normal polarity: report the pin level; open pin reads 1.
// R2 - Input mode, inverted polarity: report the inverse; open pin reads 0.
// R3 - Output True drives low, or high when inverted.
// R4 - Output False drives high, or low when inverted.
// R5 - PWM output drives a periodic wave from period and duty settings.
// R6 - Polarity setting inverts both sampled input and driven output.
// R7 - Pin 1 default function clears protection on a valid external pulse.
// R8 - A clear pulse must stay low at least 30 us; shorter ones are ignored.
// R9 - Pin 1 default function sends one pulse on output off-to-on after release.
// R10 - Every pulse is active low: high to low, then back high. With pin 1 polarity inverted, the code makes pin 1 pulses active high.
// R11 - Each pin offers default, input and output; output offers True, False, PWM.
// R12 - Normal polarity: PWM low part equals duty share of the period.
module dio_top
    import dio_pkg::*;
#(
    parameter int unsigned CLEAR_MIN_CYC = `DIO_CLEAR_MIN_CYC,
    parameter int unsigned PULSE_OUT_CYC = `DIO_PULSE_OUT_CYC
) (
    // Clock and reset.
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    // Per-pin configuration.
    input  wire dio_func_t             pin_func     [`DIO_PINS],
    input  wire dio_out_t              pin_out_sel  [`DIO_PINS],
    input  wire logic [`DIO_PINS-1:0]  pin_invert,
    input  wire logic [`DIO_PWM_W-1:0] pwm_period   [`DIO_PINS],
    input  wire logic [`DIO_PWM_W-1:0] pwm_low_time [`DIO_PINS],
    // Instrument state seen by pin 1.
    input  wire logic                  prot_active,
    input  wire logic                  output_on,
    // Pins, split into input, output and enable.
    input  wire logic [`DIO_PINS-1:0]  pin_i,
    output logic      [`DIO_PINS-1:0]  pin_o,
    output logic      [`DIO_PINS-1:0]  pin_oe,
    // Results.
    output logic      [`DIO_PINS-1:0]  in_level,
    output logic                       prot_clear
);

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers and filtered levels.

    logic [`DIO_PINS-1:0] s1_q, s2_q, s3_q, filt_q;
    logic [`DIO_PINS-1:0] s1_d, s2_d, s3_d, filt_d;

    // A change is taken once the second and third stages agree.
    always_comb begin
        s1_d   = pin_i;
        s2_d   = s1_q;
        s3_d   = s2_q;
        filt_d = filt_q;
        for (int k = 0; k < `DIO_PINS; k++) begin
            if (s2_q[k] == s3_q[k]) begin
                filt_d[k] = s3_q[k];
            end
        end
    end

    // Stages start at the pulled-up idle level.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s1_q   <= {`DIO_PINS{`DIO_IDLE_LEVEL}};
            s2_q   <= {`DIO_PINS{`DIO_IDLE_LEVEL}};
            s3_q   <= {`DIO_PINS{`DIO_IDLE_LEVEL}};
            filt_q <= {`DIO_PINS{`DIO_IDLE_LEVEL}};
        end else begin
            s1_q   <= s1_d;
            s2_q   <= s2_d;
            s3_q   <= s3_d;
            filt_q <= filt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin 1 protection-clear sequencer.

    dio_p1_state_t             p1_q, p1_d;
    logic [`DIO_TMR_W-1:0]     tmr_q, tmr_d;
    logic                      on_q, on_d;
    logic                      req_q, req_d;
    logic                      clr_q, clr_d;
    logic                      p1_active;
    logic                      p1_deflt;

    // Active input level is low, or high when the polarity is inverted.
    assign p1_active = (filt_q[0] ^ pin_invert[0]) == 1'b0; // R10 R6
    assign p1_deflt  = (pin_func[0] == DIO_FN_DEFAULT);

    // Measures incoming low time and times the pulse that pin 1 sends.
    always_comb begin
        p1_d  = p1_q;
        tmr_d = tmr_q;
        on_d  = output_on;
        req_d = req_q;
        clr_d = 1'b0;
        // Off-to-on with protection released asks for one pulse.
        if (p1_deflt && output_on && !on_q && !prot_active) begin
            req_d = 1'b1; // R9
        end
        case (p1_q)
            DIO_P1_IDLE: begin
                tmr_d = '0;
                if (!p1_deflt) begin
                    req_d = 1'b0;
                end else if (req_q) begin
                    req_d = 1'b0;
                    p1_d  = DIO_P1_PULSE;
                end else if (p1_active) begin
                    // The first filtered low cycle already counts towards the minimum width.
                    p1_d  = DIO_P1_LOW;
                    tmr_d = (`DIO_TMR_W)'(1); // R8
                end
            end
            DIO_P1_LOW: begin
                if (tmr_q < CLEAR_MIN_CYC) begin
                    tmr_d = (`DIO_TMR_W)'(tmr_q + 1'b1);
                end
                if (!p1_deflt) begin
                    p1_d = DIO_P1_IDLE;
                end else if (!p1_active) begin
                    // Pulse ends on the return to the inactive level; short ones are dropped.
                    clr_d = prot_active && (tmr_q >= CLEAR_MIN_CYC); // R7 R8 R10
                    p1_d  = DIO_P1_IDLE;
                end
            end
            DIO_P1_PULSE: begin
                tmr_d = (`DIO_TMR_W)'(tmr_q + 1'b1);
                if (!p1_deflt || (tmr_q >= PULSE_OUT_CYC - 1)) begin
                    p1_d = DIO_P1_IDLE;
                end
            end
            default: begin
                p1_d = DIO_P1_IDLE;
            end
        endcase
    end

    // Register the sequencer.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            p1_q  <= DIO_P1_IDLE;
            tmr_q <= '0;
            on_q  <= 1'b0;
            req_q <= 1'b0;
            clr_q <= 1'b0;
        end else begin
            p1_q  <= p1_d;
            tmr_q <= tmr_d;
            on_q  <= on_d;
            req_q <= req_d;
            clr_q <= clr_d;
        end
    end

    assign prot_clear = clr_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Per-pin PWM, output drive and reported level.

    logic [`DIO_PINS-1:0] po_q, po_d, oe_q, oe_d, lvl_q, lvl_d;

    for (genvar i = 0; i < `DIO_PINS; i++) begin : g_pin
        dio_pwm_if pwm_bus ();

        assign pwm_bus.period   = pwm_period[i];
        assign pwm_bus.low_time = pwm_low_time[i];

        dio_pwm u_pwm (
            .core_clk (core_clk),
            .rst      (rst),
            .bus      (pwm_bus.gen)
        );

        // Output True is low unless inverted; pin 1 pulse drives active level.
        always_comb begin
            lvl_d[i] = filt_q[i] ^ pin_invert[i]; // R1 R2 R6
            po_d[i]  = `DIO_IDLE_LEVEL;
            oe_d[i]  = 1'b0;
            case (pin_func[i])
                DIO_FN_OUTPUT: begin
                    oe_d[i] = 1'b1;
                    case (pin_out_sel[i])
                        DIO_OUT_TRUE:  po_d[i] = pin_invert[i];                        // R3
                        DIO_OUT_FALSE: po_d[i] = ~pin_invert[i];                       // R4
                        DIO_OUT_PWM:   po_d[i] = ~pwm_bus.active ^ pin_invert[i];     // R5 R6 R12
                        default:       po_d[i] = ~pin_invert[i];
                    endcase
                end
                DIO_FN_DEFAULT: begin
                    if ((i == 0) && (p1_q == DIO_P1_PULSE)) begin
                        oe_d[i] = 1'b1;
                        po_d[i] = pin_invert[i]; // R9 R10
                    end
                end
                default: begin
                    oe_d[i] = 1'b0; // R11
                end
            endcase
        end
    end

    // Register the pin drive and reported levels.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            po_q  <= {`DIO_PINS{`DIO_IDLE_LEVEL}};
            oe_q  <= '0;
            lvl_q <= '0;
        end else begin
            po_q  <= po_d;
            oe_q  <= oe_d;
            lvl_q <= lvl_d;
        end
    end

    assign pin_o    = po_q;
    assign pin_oe   = oe_q;
    assign in_level = lvl_q;

endmodule

`default_nettype wire

// file: verif/dio_ext_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "dio_defs.svh"

// External instrument on the pins; a released or open pin floats high.
module dio_ext_model (
    // Clock.
    input  wire logic                 core_clk,
    // Pins.
    input  wire logic [`DIO_PINS-1:0] pin_o,
    input  wire logic [`DIO_PINS-1:0] pin_oe,
    output wire logic [`DIO_PINS-1:0] pin_i
);
    logic [`DIO_PINS-1:0] en_q = '0;
    logic [`DIO_PINS-1:0] lv_q = '1;

    // Wire level from both drivers, pulled high when nobody drives.
    assign pin_i = pin_oe & pin_o | ~pin_oe & (~en_q | lv_q);

    // Drives the chosen pins just after an edge.
    task automatic set(input logic [`DIO_PINS-1:0] en, input logic [`DIO_PINS-1:0] lv);
        @(posedge core_clk);
        en_q <= en;
        lv_q <= lv;
    endtask

    // Pulls pin 1 low for n cycles, then lets it go back high.
    task automatic low_pulse(input int n);
        set(7'h01, 7'h00);
        repeat (n) @(posedge core_clk);
        en_q <= '0;
    endtask
endmodule

`default_nettype wire

// file: verif/dio_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "dio_defs.svh"

// Watches the pin block from its ports.
module dio_top_sva
    import dio_pkg::*;
#(
    parameter int unsigned CLEAR_MIN_CYC = 8,
    parameter int unsigned PULSE_OUT_CYC = 8
) (
    // Clock, reset and settings.
    input wire logic                 core_clk,
    input wire logic                 rst,
    input wire dio_func_t            pin_func    [`DIO_PINS],
    input wire dio_out_t             pin_out_sel [`DIO_PINS],
    input wire logic [`DIO_PINS-1:0] pin_invert,
    input wire logic                 prot_active,
    input wire logic                 output_on,
    // Pins and results.
    input wire logic [`DIO_PINS-1:0] pin_i,
    input wire logic [`DIO_PINS-1:0] pin_o,
    input wire logic [`DIO_PINS-1:0] pin_oe,
    input wire logic [`DIO_PINS-1:0] in_level,
    input wire logic                 prot_clear
);
    logic [31:0] run_d, run_q, len_d, len_q, oe_d, oe_q;

    // Length of the last active run on pin 1 and of its own sent pulse.
    always_comb begin
        run_d = (pin_i[0] == pin_invert[0]) ? run_q + 32'h1 : 32'h0;
        len_d = (pin_i[0] != pin_invert[0] && run_q != 32'h0) ? run_q : len_q;
        oe_d  = (pin_oe[0] && pin_func[0] == DIO_FN_DEFAULT) ? oe_q + 32'h1 : 32'h0;
    end
    always_ff @(posedge core_clk) begin
        run_q <= rst ? 32'h0 : run_d;
        len_q <= rst ? 32'h0 : len_d;
        oe_q  <= rst ? 32'h0 : oe_d;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_level_drive: assert property (
        pin_func[1] == DIO_FN_OUTPUT && pin_out_sel[1] != DIO_OUT_PWM |=> pin_oe[1] &&
        pin_o[1] == ($past(pin_out_sel[1]) == DIO_OUT_TRUE ? $past(pin_invert[1]) : !$past(pin_invert[1])))
        else $error("pin 2 output level wrong");
    chk_input_release: assert property (
        pin_func[2] == DIO_FN_INPUT |=> !pin_oe[2]) else $error("input pin is driven");
    chk_input_follow: assert property (
        ($stable(pin_i[2]) && $stable(pin_invert[2])) [*6] |-> in_level[2] == (pin_i[2] ^ pin_invert[2]))
        else $error("reported input level wrong");
    chk_clear_single: assert property (
        prot_clear |=> !prot_clear) else $error("clear longer than one cycle");
    chk_clear_width: assert property (
        prot_clear |-> len_q >= CLEAR_MIN_CYC) else $error("clear after a short pulse");
    chk_clear_cause: assert property (
        prot_clear |-> $past(pin_func[0]) == DIO_FN_DEFAULT && $past(prot_active))
        else $error("clear without protection");
    chk_pulse_start: assert property (
        $rose(output_on) && !prot_active && pin_func[0] == DIO_FN_DEFAULT && !pin_oe[0] &&
        pin_i[0] != pin_invert[0] |-> ##[1:4] (pin_oe[0] && pin_o[0] == pin_invert[0]))
        else $error("no pulse on output on");
    chk_pulse_width: assert property (
        $fell(pin_oe[0]) && pin_func[0] == DIO_FN_DEFAULT && $past(pin_func[0], 2) == DIO_FN_DEFAULT
        |-> oe_q == PULSE_OUT_CYC) else $error("sent pulse width wrong");
endmodule

bind dio_top dio_top_sva #(.CLEAR_MIN_CYC(CLEAR_MIN_CYC), .PULSE_OUT_CYC(PULSE_OUT_CYC)) u_sva (
    .core_clk(core_clk), .rst(rst), .pin_func(pin_func), .pin_out_sel(pin_out_sel),
    .pin_invert(pin_invert), .prot_active(prot_active), .output_on(output_on), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe(pin_oe), .in_level(in_level), .prot_clear(prot_clear));

`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dio_defs.svh"

module testbench
    import dio_pkg::*;
;
    localparam int CM = 8;
    typedef struct {int kind; int idx; logic [31:0] exp;} dio_note_t;
    logic                  core_clk = 1'b0;
    logic                  rst = 1'b1;
    dio_func_t             pin_func [`DIO_PINS];
    dio_out_t              pin_out_sel [`DIO_PINS];
    logic [`DIO_PINS-1:0]  pin_invert = '0;
    logic [`DIO_PWM_W-1:0] pwm_period [`DIO_PINS];
    logic [`DIO_PWM_W-1:0] pwm_low_time [`DIO_PINS];
    logic                  prot_active = 1'b0, output_on = 1'b0, look = 1'b0, win = 1'b0;
    logic [`DIO_PINS-1:0]  pin_i, pin_o, pin_oe, in_level;
    logic                  prot_clear;
    logic [7:0]            rnd = 8'h56;
    logic [31:0]           lows = '0;
    int                    mismatches = 0, n_checks = 0;
    dio_note_t             q[$];
    int                    cq[$];

    always #2 core_clk = ~core_clk;

    dio_top #(.CLEAR_MIN_CYC(CM), .PULSE_OUT_CYC(8)) DUT (.core_clk(core_clk), .rst(rst),
        .pin_func(pin_func), .pin_out_sel(pin_out_sel), .pin_invert(pin_invert), .pwm_period(pwm_period),
        .pwm_low_time(pwm_low_time), .prot_active(prot_active), .output_on(output_on), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe(pin_oe), .in_level(in_level), .prot_clear(prot_clear));
    dio_ext_model ext (.core_clk(core_clk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic cmp_lvl(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic cmp_clr(input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch prot_clear expected %0b seen %0b", e, g);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Queues a note and asks the monitor to compare it on the next edge.
    task automatic note(input int k, input int i, input logic [31:0] e);
        q.push_back('{k, i, e});
        look <= 1'b1;
        @(posedge core_clk);
        look <= 1'b0;
        @(posedge core_clk);
    endtask

    // One active-low pulse into pin 1, then time for the answer.
    task automatic pulse(input int n);
        ext.low_pulse(n);
        repeat (16) @(posedge core_clk);
    endtask

    // Monitor: counts PWM low cycles and takes the oldest note per result.
    always @(posedge core_clk) begin
        dio_note_t n;
        if (win) lows <= lows + 32'(pin_o[3] == 1'b0);
        if (look) begin
            n = q.pop_front();
            case (n.kind)
                0: cmp_lvl("in_level", n.exp, 32'(in_level[n.idx]));
                1: cmp_lvl("pin_o", n.exp, 32'(pin_o[n.idx]));
                2: cmp_lvl("pin_oe", n.exp, 32'(pin_oe[n.idx]));
                default: begin
                    cmp_lvl("pwm_low", n.exp, lows);
                    lows <= '0;
                end
            endcase
        end
        if (!rst && prot_clear !== 1'b0) begin
            cmp_clr(cq.size() != 0, prot_clear);
            if (cq.size() != 0) void'(cq.pop_front());
        end
    end

    // Main sequence.
    initial begin
        logic [7:0] a, b;
        for (int i = 0; i < `DIO_PINS; i++) begin
            pin_func[i] = DIO_FN_INPUT;
            pin_out_sel[i] = DIO_OUT_TRUE;
            pwm_period[i] = '0;
            pwm_low_time[i] = '0;
        end
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        repeat (4) begin
            a = lfsr(rnd);
            b = lfsr(a);
            rnd = lfsr(b);
            pin_invert <= a[6:0];
            ext.set(b[6:0], rnd[6:0]);
            repeat (8) @(posedge core_clk);
            for (int i = 0; i < 7; i++) note(0, i, 32'((b[i] ? rnd[i] : 1'b1) ^ a[i]));
        end
        ext.set(7'h00, 7'h7f);
        for (int s = 0; s < 2; s++) begin
            rnd = lfsr(rnd);
            for (int i = 0; i < 7; i++) begin
                pin_func[i] <= DIO_FN_OUTPUT;
                pin_out_sel[i] <= s ? DIO_OUT_FALSE : DIO_OUT_TRUE;
            end
            pin_invert <= rnd[6:0];
            repeat (2) @(posedge core_clk);
            for (int i = 0; i < 7; i++) begin
                note(1, i, 32'(rnd[i] ^ s[0]));
                note(2, i, 32'h1);
            end
        end
        pin_out_sel[3] <= DIO_OUT_PWM;
        pin_invert <= '0;
        pwm_period[3] <= 32'ha;
        pwm_low_time[3] <= 32'h3;
        repeat (4) @(posedge core_clk);
        win <= 1'b1;
        repeat (40) @(posedge core_clk);
        win <= 1'b0;
        note(3, 3, 32'hc);
        pin_func[0] <= DIO_FN_DEFAULT;
        prot_active <= 1'b1;
        cq.push_back(1);
        pulse(CM + 2);
        pulse(CM - 1);
        cq.push_back(1);
        pulse(CM);
        prot_active <= 1'b0;
        pulse(CM + 2);
        cmp_clr(1'b0, cq.size() != 0);
        output_on <= 1'b1;
        repeat (4) @(posedge core_clk);
        note(2, 0, 32'h1);
        note(1, 0, 32'h0);
        repeat (12) @(posedge core_clk);
        note(2, 0, 32'h0);
        output_on <= 1'b0;
        prot_active <= 1'b1;
        @(posedge core_clk);
        output_on <= 1'b1;
        repeat (4) @(posedge core_clk);
        note(2, 0, 32'h0);
        end_of_test();
    end
endmodule

`default_nettype wire
